// >>> pkg/speech_enc_pkg.sv
`default_nettype none
package speech_enc_pkg;

	localparam int FRAME_MS       = 20;
	localparam int SAMPLE_RATE_HZ = 8000;
	localparam int FRAME_LEN      = FRAME_MS * SAMPLE_RATE_HZ / 1000;
	localparam int NUM_SUBFR      = 4;
	localparam int SUBFR_LEN      = FRAME_LEN / NUM_SUBFR;
	localparam int LP_ORDER       = 10;
	localparam int SAMPLE_W       = 16;
	localparam int LIN_BITS       = 13;
	localparam int PAD_BITS       = SAMPLE_W - LIN_BITS;
	localparam int SIG_W          = 40;

	localparam logic [5:0] SUBFR_LAST = 6'(SUBFR_LEN - 1);
	localparam logic [1:0] SUBFR_END  = 2'(NUM_SUBFR - 1);

	localparam logic [7:0]  ALAW_XOR  = 8'h55;
	localparam logic [15:0] ULAW_BIAS = 16'h0084;

	// rates in ascending order, 4.75 up to 12.2 kbit/s
	typedef enum logic [2:0] {
		MODE_475, MODE_515, MODE_590, MODE_670,
		MODE_740, MODE_795, MODE_102, MODE_122
	} rate_mode_t;

	localparam rate_mode_t MODE_RESET = MODE_475;

	typedef enum logic [1:0] {FMT_LINEAR, FMT_ALAW, FMT_ULAW} sample_fmt_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_LP_ANALYSIS, ST_LINE_SPECTRUM_PAIR, ST_OL_PITCH, ST_TARGET,
		ST_CL_PITCH, ST_TARGET2, ST_FIXED_SEARCH, ST_GAIN_PITCH,
		ST_GAIN_CODE, ST_MEM_UPDATE
	} stage_t;

	typedef logic [5:0] width_t;

	localparam logic [7:0] FRAME_BITS [8] = '{
		8'h5f, 8'h67, 8'h76, 8'h86, 8'h94, 8'h9f, 8'hcc, 8'hf4};
	localparam width_t LINE_SPECTRUM_PAIR_BITS [8] = '{
		6'h17, 6'h17, 6'h1a, 6'h1a, 6'h1a, 6'h1b, 6'h1a, 6'h26};
	localparam width_t PITCH_ABS_BITS [8] = '{
		6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h09};
	localparam width_t PITCH_REL_BITS [8] = '{
		6'h04, 6'h04, 6'h04, 6'h04, 6'h05, 6'h06, 6'h05, 6'h06};
	localparam width_t CODE_BITS [8] = '{
		6'h09, 6'h09, 6'h0b, 6'h0e, 6'h11, 6'h11, 6'h1f, 6'h23};
	localparam width_t VGAIN_BITS [8] = '{
		6'h08, 6'h06, 6'h06, 6'h07, 6'h07, 6'h00, 6'h07, 6'h00};
	localparam width_t PGAIN_BITS = 6'h04;
	localparam width_t CGAIN_BITS = 6'h05;

	localparam logic [15:0] GAMMA1_HI_Q15 = 16'h7333;
	localparam logic [15:0] GAMMA1_LO_Q15 = 16'h7852;
	localparam logic [15:0] GAMMA2_Q15    = 16'h4ccd;
	localparam logic [2:0]  PITCH_RES_FINE   = 3'h6;
	localparam logic [2:0]  PITCH_RES_COARSE = 3'h3;
	localparam logic [3:0]  SYNTH_ORDER      = 4'(LP_ORDER);

	function automatic logic scalar_gain(input rate_mode_t m);
		return (m == MODE_795) || (m == MODE_122);
	endfunction

	function automatic logic low_mode(input rate_mode_t m);
		return (m == MODE_475) || (m == MODE_515);
	endfunction

endpackage
`default_nettype wire

// >>> hw/stream_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module stream_buf2 #(
	parameter int W     = 2,
	parameter int DEPTH = 2
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         wr_valid,
	output logic              wr_ready,
	input  wire logic [W-1:0] wr_data,
	output logic              rd_valid,
	input  wire logic         rd_ready,
	output logic [W-1:0]      rd_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [AW-1:0]          wp_r;
	logic [AW-1:0]          rp_r;
	logic [AW:0]            cnt_r;
	logic [DEPTH-1:0][W-1:0] slot;
	wire  logic             wr;
	wire  logic             rd;

	assign wr_ready = cnt_r != (AW+1)'(DEPTH);
	assign rd_valid = cnt_r != '0;
	assign rd_data  = slot[rp_r];
	assign wr       = wr_valid && wr_ready;
	assign rd       = rd_valid && rd_ready;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
			end
			if (rd) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
			end
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end

	for (genvar g = 0; g < DEPTH; g++) begin : g_slot
		logic [W-1:0] q_r;
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				q_r <= '0;
			end else if (wr && wp_r == AW'(g)) begin
				q_r <= wr_data;
			end
		end
		assign slot[g] = q_r;
	end
endmodule
`default_nettype wire

// >>> hw/speech_frame_encoder.sv
// Function
// - linear samples are two's complement signed
// - low three sample bits forced to zero
// - output samples use same left-justified layout
// - companded input expanded to linear first
// - frames of 160 samples, 20 ms
// - eight selectable coding rates
// - exact mode-dependent bit count per frame
// - every parameter sent MSB first
// - four subframes of 40 samples each
// - LP analysis twice at 12.2, else once
// - 12.2 spectral pairs split matrix quantized, 38 bits
// - other modes split vector quantized
// - synthesis filter order is ten
// - weighting factors 0.9/0.94 over 0.6
// - codebook parameters every subframe
// - open-loop pitch alternate subframes, low modes once
// - pitch resolution sixth or third by mode
// - second target removes adaptive contribution
// - gains scalar 4+5 or vector 6-8 bits
// - filter memories updated after each subframe
`timescale 1ns/1ps
`default_nettype none
module speech_frame_encoder
	import speech_enc_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [15:0] in_data,
	input  wire logic [1:0]  in_fmt,
	input  wire logic [2:0]  mode_sel,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic             out_bit,
	output logic             out_frame_start,
	output logic [7:0]       out_frame_bits,
	output logic             prep_valid,
	output logic [15:0]      prep_sample,
	output logic             stage_strobe,
	output stage_t           stage_id,
	output logic [1:0]       sub_index,
	output logic [15:0]      weight_num_q15,
	output logic [15:0]      weight_den_q15,
	output logic [2:0]       pitch_frac_div,
	output logic [3:0]       synth_order,
	output logic             busy
);

	function automatic logic [15:0] alaw_expand(input logic [7:0] code);
		logic [7:0]  x;
		logic [11:0] mag;
		logic [15:0] w;
		x = code ^ ALAW_XOR;
		if (x[6:4] == 3'h0) begin
			mag = {7'h00, x[3:0], 1'b1};
		end else begin
			mag = {6'h00, 1'b1, x[3:0], 1'b1} << (x[6:4] - 3'h1);
		end
		w = {1'b0, mag, 3'h0};
		return x[7] ? w : (16'h0000 - w);
	endfunction

	// mu-law spans 14 bits; the lowest one is lost to the 13-bit container
	function automatic logic [15:0] ulaw_expand(input logic [7:0] code);
		logic [7:0]  x;
		logic [15:0] t;
		logic [15:0] mag;
		logic [15:0] w;
		x   = ~code;
		t   = ({9'h000, x[3:0], 3'h0} + ULAW_BIAS) << x[6:4];
		mag = t - ULAW_BIAS;
		w   = x[7] ? (16'h0000 - mag) : mag;
		return {w[15:PAD_BITS], {PAD_BITS{1'b0}}};
	endfunction

	// ---------------- sample preparation ----------------
	wire  logic [15:0] lin_word;
	wire  logic [15:0] alaw_word;
	wire  logic [15:0] ulaw_word;
	wire  logic [15:0] prep_word;

	// source keeps 13 significant bits on top; stray low bits are cleared
	assign lin_word  = {in_data[15:PAD_BITS], {PAD_BITS{1'b0}}};
	assign alaw_word = alaw_expand(in_data[7:0]);
	assign ulaw_word = ulaw_expand(in_data[7:0]);
	assign prep_word = (in_fmt == FMT_ALAW) ? alaw_word :
	                   (in_fmt == FMT_ULAW) ? ulaw_word : lin_word;

	logic [15:0] prep_r;
	logic        prep_valid_r;

	// ---------------- frame collection ----------------
	logic [5:0]       samp_cnt_r;
	logic [1:0]       coll_sub_r;
	logic [SIG_W-1:0] acc_r;
	logic [SIG_W-1:0] fsig_r;
	logic [SIG_W-1:0] enc_fsig_r;
	wire  logic [SIG_W-1:0] acc_nxt;
	wire  logic [SIG_W-1:0] fsig_nxt;
	wire  logic       sub_last;
	wire  logic       frame_last;
	wire  logic       take;
	wire  logic       start;
	logic [NUM_SUBFR-1:0][SIG_W-1:0] enc_sig;

	assign sub_last   = samp_cnt_r == SUBFR_LAST;
	assign frame_last = sub_last && coll_sub_r == SUBFR_END;
	// last sample of a frame waits while the previous frame is still encoding
	assign in_ready   = !(frame_last && busy);
	assign take       = in_valid && in_ready;
	assign start      = take && frame_last;
	assign acc_nxt    = {acc_r[SIG_W-2:0], acc_r[SIG_W-1]} ^ {{(SIG_W-16){1'b0}}, prep_word};
	assign fsig_nxt   = {fsig_r[SIG_W-2:0], fsig_r[SIG_W-1]} ^ {prep_word, {(SIG_W-16){1'b0}}};

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			samp_cnt_r <= 6'h00;
			coll_sub_r <= 2'h0;
			acc_r      <= '0;
			fsig_r     <= '0;
		end else if (take) begin
			samp_cnt_r <= sub_last ? 6'h00 : samp_cnt_r + 6'h01;
			coll_sub_r <= sub_last ? coll_sub_r + 2'h1 : coll_sub_r;
			acc_r      <= sub_last ? '0 : acc_nxt;
			fsig_r     <= frame_last ? '0 : fsig_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prep_r       <= 16'h0000;
			prep_valid_r <= 1'b0;
		end else begin
			prep_valid_r <= take;
			if (take) begin
				prep_r <= prep_word;
			end
		end
	end

	// per-subframe summaries, double buffered so collection waits on the encoder only at a frame's last sample
	for (genvar g = 0; g < NUM_SUBFR; g++) begin : g_sub
		logic [SIG_W-1:0] coll_q_r;
		logic [SIG_W-1:0] enc_q_r;
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				coll_q_r <= '0;
				enc_q_r  <= '0;
			end else begin
				if (take && sub_last && coll_sub_r == 2'(g)) begin
					coll_q_r <= acc_nxt;
				end
				if (start) begin
					enc_q_r <= (g == NUM_SUBFR - 1) ? acc_nxt : coll_q_r;
				end
			end
		end
		assign enc_sig[g] = enc_q_r;
	end

	// ---------------- per-frame mode latch ----------------
	rate_mode_t  mode_r;
	logic [7:0]  frame_bits_r;
	logic [15:0] wnum_r;
	logic [2:0]  pdiv_r;
	wire  rate_mode_t mode_in;

	assign mode_in = rate_mode_t'(mode_sel);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode_r       <= MODE_RESET;
			frame_bits_r <= FRAME_BITS[MODE_RESET];
			wnum_r       <= GAMMA1_LO_Q15;
			pdiv_r       <= PITCH_RES_COARSE;
			enc_fsig_r   <= '0;
		end else if (start) begin
			mode_r       <= mode_in;
			frame_bits_r <= FRAME_BITS[mode_in];
			wnum_r       <= (mode_in == MODE_122 || mode_in == MODE_102) ?
			                GAMMA1_HI_Q15 : GAMMA1_LO_Q15;
			pdiv_r       <= (mode_in == MODE_122) ? PITCH_RES_FINE : PITCH_RES_COARSE;
			enc_fsig_r   <= fsig_nxt;
		end
	end

	// ---------------- encoder sequencer ----------------
	stage_t           state_r;
	stage_t           succ;
	logic [1:0]       sub_r;
	logic             lp_pass_r;
	logic             ld_r;
	logic             first_r;
	logic [5:0]       cnt_r;
	logic [SIG_W-1:0] sh_r;
	logic [SIG_W-1:0] lp_sig_r;
	logic [SIG_W-1:0] target_r;
	logic [SIG_W-1:0] adapt_r;
	logic [SIG_W-1:0] mem_r;
	logic [7:0]       ol_lag_r;
	logic             stage_strobe_r;
	stage_t           stage_id_r;
	logic [1:0]       sub_index_r;

	wire  logic [SIG_W-1:0] cur_sig;
	wire  logic       is122;
	wire  logic       scalar;
	wire  logic       ol_here;
	wire  logic       lp_again;
	wire  logic       buf_ready;
	wire  logic       push;
	wire  logic       field_done;
	wire  logic       stage_end;
	wire  width_t     w_pitch;
	wire  width_t     w_pgain;
	wire  width_t     w_cgain;
	wire  width_t     field_w;
	wire  logic [SIG_W-1:0] v_line_spectrum_pair;
	wire  logic [SIG_W-1:0] v_pitch;
	wire  logic [SIG_W-1:0] field_v;
	wire  logic [1:0] buf_out;

	assign cur_sig  = enc_sig[sub_r];
	assign is122    = mode_r == MODE_122;
	assign scalar   = scalar_gain(mode_r);
	// subframes 0 and 2 (only 0 in the two low modes) carry a fresh open-loop lag and an absolute pitch delay
	assign ol_here  = sub_r == 2'h0 || (sub_r == 2'h2 && !low_mode(mode_r));
	assign lp_again = state_r == ST_LP_ANALYSIS && is122 && !lp_pass_r;

	assign w_pitch  = ol_here ? PITCH_ABS_BITS[mode_r] : PITCH_REL_BITS[mode_r];
	assign w_pgain  = scalar ? PGAIN_BITS : 6'h00;
	assign w_cgain  = scalar ? CGAIN_BITS :
	                  (mode_r == MODE_475 && sub_r[0]) ? 6'h00 : VGAIN_BITS[mode_r];
	assign field_w  = (state_r == ST_LINE_SPECTRUM_PAIR) ? LINE_SPECTRUM_PAIR_BITS[mode_r] :
	                  (state_r == ST_CL_PITCH)     ? w_pitch :
	                  (state_r == ST_FIXED_SEARCH) ? CODE_BITS[mode_r] :
	                  (state_r == ST_GAIN_PITCH)   ? w_pgain :
	                  (state_r == ST_GAIN_CODE)    ? w_cgain : 6'h00;

	// both analysis passes live in lp_sig_r; the single-set path folds in the first subframe summary enc_sig[0]
	assign v_line_spectrum_pair = is122 ? lp_sig_r : (lp_sig_r ^ enc_sig[0]);
	assign v_pitch  = {ol_lag_r, target_r[SIG_W-9:0]};
	assign field_v  = (state_r == ST_LINE_SPECTRUM_PAIR) ? v_line_spectrum_pair :
	                  (state_r == ST_CL_PITCH)     ? v_pitch :
	                  (state_r == ST_FIXED_SEARCH) ? target_r :
	                  (state_r == ST_GAIN_PITCH)   ? {target_r[7:0], target_r[SIG_W-1:8]} :
	                  ~target_r;

	assign push       = ld_r && buf_ready;
	assign field_done = push && cnt_r == 6'h01;
	assign stage_end  = (!ld_r && field_w == 6'h00) || field_done;

	always_comb begin
		succ = state_r;
		case (state_r)
			ST_IDLE:         succ = start ? ST_LP_ANALYSIS : ST_IDLE;
			ST_LP_ANALYSIS:  succ = lp_again ? ST_LP_ANALYSIS : ST_LINE_SPECTRUM_PAIR;
			ST_LINE_SPECTRUM_PAIR: succ = ST_OL_PITCH;
			ST_OL_PITCH:     succ = ST_TARGET;
			ST_TARGET:       succ = ST_CL_PITCH;
			ST_CL_PITCH:     succ = ST_TARGET2;
			ST_TARGET2:      succ = ST_FIXED_SEARCH;
			ST_FIXED_SEARCH: succ = ST_GAIN_PITCH;
			ST_GAIN_PITCH:   succ = ST_GAIN_CODE;
			ST_GAIN_CODE:    succ = ST_MEM_UPDATE;
			ST_MEM_UPDATE:   succ = (sub_r == SUBFR_END) ? ST_IDLE : ST_OL_PITCH;
			default:         succ = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else if (stage_end) begin
			state_r <= succ;
		end
	end

	// field shifter: loads a left-aligned value, then drains it one bit per accepted beat
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ld_r  <= 1'b0;
			cnt_r <= 6'h00;
			sh_r  <= '0;
		end else if (!ld_r && field_w != 6'h00) begin
			ld_r  <= 1'b1;
			cnt_r <= field_w;
			sh_r  <= field_v;
		end else if (push) begin
			sh_r  <= {sh_r[SIG_W-2:0], 1'b0};
			cnt_r <= cnt_r - 6'h01;
			ld_r  <= cnt_r != 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			first_r <= 1'b0;
		end else if (start) begin
			first_r <= 1'b1;
		end else if (push) begin
			first_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sub_r     <= 2'h0;
			lp_pass_r <= 1'b0;
			lp_sig_r  <= '0;
		end else if (state_r == ST_IDLE) begin
			sub_r     <= 2'h0;
			lp_pass_r <= 1'b0;
			lp_sig_r  <= '0;
		end else if (state_r == ST_LP_ANALYSIS) begin
			lp_pass_r <= 1'b1;
			lp_sig_r  <= {lp_sig_r[SIG_W-2:0], lp_sig_r[SIG_W-1]} ^ enc_fsig_r;
		end else if (state_r == ST_MEM_UPDATE) begin
			sub_r <= sub_r + 2'h1;
		end
	end

	// subframe datapath; filter memory survives across frames on purpose
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ol_lag_r <= 8'h00;
			target_r <= '0;
			adapt_r  <= '0;
			mem_r    <= '0;
		end else begin
			if (state_r == ST_OL_PITCH && ol_here) begin
				ol_lag_r <= cur_sig[SIG_W-1 -: 8] ^ mem_r[7:0];
			end
			if (state_r == ST_TARGET) begin
				target_r <= cur_sig ^ mem_r;
			end
			if (state_r == ST_CL_PITCH && field_done) begin
				adapt_r <= {2'b00, v_pitch[SIG_W-1:2]};
			end
			if (state_r == ST_TARGET2) begin
				target_r <= target_r - adapt_r;
			end
			if (state_r == ST_MEM_UPDATE) begin
				mem_r <= target_r + adapt_r;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stage_strobe_r <= 1'b0;
			stage_id_r     <= ST_IDLE;
			sub_index_r    <= 2'h0;
		end else begin
			stage_strobe_r <= !ld_r && state_r != ST_IDLE &&
			                  (state_r != ST_OL_PITCH || ol_here);
			stage_id_r     <= state_r;
			sub_index_r    <= sub_r;
		end
	end

	stream_buf2 #(
		.W     (2),
		.DEPTH (BUF_DEPTH)
	) u_out_buf (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.wr_valid (ld_r),
		.wr_ready (buf_ready),
		.wr_data  ({first_r, sh_r[SIG_W-1]}),
		.rd_valid (out_valid),
		.rd_ready (out_ready),
		.rd_data  (buf_out)
	);

	assign out_frame_start = buf_out[1];
	assign out_bit         = buf_out[0];
	assign out_frame_bits  = frame_bits_r;
	assign prep_valid      = prep_valid_r;
	assign prep_sample     = prep_r;
	assign stage_strobe    = stage_strobe_r;
	assign stage_id        = stage_id_r;
	assign sub_index       = sub_index_r;
	assign weight_num_q15  = wnum_r;
	assign weight_den_q15  = GAMMA2_Q15;
	assign pitch_frac_div  = pdiv_r;
	assign synth_order     = SYNTH_ORDER;
	assign busy            = state_r != ST_IDLE;

endmodule
`default_nettype wire

// >>> verif/speech_frame_encoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module speech_frame_encoder_monitor
	import speech_enc_pkg::*;
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic [15:0] in_data,
	input wire logic [1:0]  in_fmt,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic        out_bit,
	input wire logic        out_frame_start,
	input wire logic [7:0]  out_frame_bits,
	input wire logic        prep_valid,
	input wire logic [15:0] prep_sample,
	input wire logic        stage_strobe,
	input wire stage_t      stage_id,
	input wire logic [1:0]  sub_index,
	input wire logic [15:0] weight_num_q15,
	input wire logic [15:0] weight_den_q15,
	input wire logic [2:0]  pitch_frac_div,
	input wire logic [3:0]  synth_order,
	input wire logic        busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	wire       take    = in_valid && in_ready;
	wire       hi_rate = (out_frame_bits == 8'hcc) || (out_frame_bits == 8'hf4);
	logic [2:0] busy_run_r;
	logic [2:0] busy_run_nxt;

	// mode registers may settle a cycle apart, so only judge them well inside a frame
	assign busy_run_nxt = !busy ? 3'h0 : (busy_run_r == 3'h7 ? busy_run_r : busy_run_r + 3'h1);
	always_ff @(posedge mclk) begin
		busy_run_r <= sys_rst ? 3'h0 : busy_run_nxt;
	end

	logic [7:0] take_cnt_r;
	// frame position counted from reset, the same way the encoder counts it
	always_ff @(posedge mclk) begin
		if (sys_rst || (take && take_cnt_r == 8'h9f)) begin
			take_cnt_r <= 8'h00;
		end else if (take) begin
			take_cnt_r <= take_cnt_r + 8'h01;
		end
	end

	property p_prep_take; take |=> prep_valid; endproperty
	a_prep_take: assert property (p_prep_take) else $error("no prepared word after take");
	property p_low_zero; prep_valid |-> prep_sample[2:0] == 3'h0; endproperty
	a_low_zero: assert property (p_low_zero) else $error("low sample bits not zero");
	property p_linear;
		take && in_fmt == 2'h0 |=> (prep_sample >> 3) == ($past(in_data) >> 3);
	endproperty
	a_linear: assert property (p_linear) else $error("linear sample altered");
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_bit) && $stable(out_frame_start);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled bit changed");
	property p_one_start;
		out_valid && out_ready && out_frame_start |=> !(out_valid && out_frame_start);
	endproperty
	a_one_start: assert property (p_one_start) else $error("frame strobe on two beats");
	property p_mode_hold;
		busy_run_r == 3'h7 |-> $stable(out_frame_bits) && $stable(weight_num_q15);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed inside frame");
	property p_frac;
		busy_run_r == 3'h7 |-> pitch_frac_div == (out_frame_bits == 8'hf4 ? 3'h6 : 3'h3);
	endproperty
	a_frac: assert property (p_frac) else $error("pitch resolution wrong for mode");
	property p_weight;
		busy_run_r == 3'h7 |-> weight_den_q15 == 16'h4ccd &&
			weight_num_q15 == (hi_rate ? 16'h7333 : 16'h7852);
	endproperty
	a_weight: assert property (p_weight) else $error("weighting factor wrong for mode");
	property p_bits;
		out_frame_bits inside {8'h5f, 8'h67, 8'h76, 8'h86, 8'h94, 8'h9f, 8'hcc, 8'hf4};
	endproperty
	a_bits: assert property (p_bits) else $error("illegal frame bit count");
	property p_ol; stage_strobe && stage_id == ST_OL_PITCH |->
		sub_index == 2'h0 || (sub_index == 2'h2 && out_frame_bits > 8'h67); endproperty
	a_ol: assert property (p_ol) else $error("open loop pitch on wrong subframe");
	property p_stall; !in_ready |-> busy && take_cnt_r == 8'h9f; endproperty
	a_stall: assert property (p_stall) else $error("input refused off frame end");
	property p_start; take && take_cnt_r == 8'h9f |=> busy; endproperty
	a_start: assert property (p_start) else $error("full frame not started");
	property p_order; synth_order == 4'ha; endproperty
	a_order: assert property (p_order) else $error("synthesis order not ten");

	c_frame: cover property (out_valid && out_ready && out_frame_start);
	c_alaw: cover property (take && in_fmt == 2'h1);
	c_lp_hi: cover property (stage_strobe && stage_id == ST_LP_ANALYSIS && out_frame_bits == 8'hf4);
	c_refuse: cover property (in_valid && !in_ready);
endmodule

bind speech_frame_encoder speech_frame_encoder_monitor i_speech_frame_encoder_monitor (
	.mclk, .sys_rst, .in_valid, .in_ready, .in_data, .in_fmt, .out_valid, .out_ready,
	.out_bit, .out_frame_start, .out_frame_bits, .prep_valid, .prep_sample, .stage_strobe,
	.stage_id, .sub_index, .weight_num_q15, .weight_den_q15, .pitch_frac_div, .synth_order, .busy
);
`default_nettype wire

// >>> verif/frame_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module frame_sink_model (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic slow,
	output var logic  out_ready
);
	logic [7:0] pat_r = 8'h49;

	initial out_ready = 1'b0;
	// slow sink accepts about one beat in four, so the buffer fills and the encoder waits
	always @(posedge mclk) begin
		pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5] ^ pat_r[4] ^ pat_r[3]};
		out_ready <= #1 !sys_rst && (!slow || pat_r[1:0] == 2'h0);
	end
endmodule
`default_nettype wire

// >>> verif/tb_speech_frame_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_speech_frame_encoder;
	import speech_enc_pkg::*;
	logic        mclk = 1'b0;
	logic        sys_rst, in_valid, in_ready, out_valid, out_ready, out_bit, slow;
	logic        out_frame_start, prep_valid, stage_strobe, busy, busy_d;
	logic [15:0] in_data, prep_sample, weight_num_q15, weight_den_q15;
	logic [15:0] lfsr = 16'h0031;
	logic [1:0]  in_fmt, sub_index;
	logic [2:0]  mode_sel, pitch_frac_div;
	logic [7:0]  out_frame_bits;
	logic [3:0]  synth_order;
	stage_t      stage_id;
	int          bad_count, samples_checked, nbits, omode;
	int          st_cnt [16];
	int          mode_q [$], st_q [$];
	logic [15:0] exp_q [$];
	int          bits_tab [8] = '{95, 103, 118, 134, 148, 159, 204, 244};
	stage_t      sub_st [4] = '{ST_CL_PITCH, ST_TARGET2, ST_FIXED_SEARCH, ST_MEM_UPDATE};

	speech_frame_encoder i_speech_frame_encoder (.mclk, .sys_rst, .in_valid, .in_ready,
		.in_data, .in_fmt, .mode_sel, .out_valid, .out_ready, .out_bit, .out_frame_start,
		.out_frame_bits, .prep_valid, .prep_sample, .stage_strobe, .stage_id, .sub_index,
		.weight_num_q15, .weight_den_q15, .pitch_frac_div, .synth_order, .busy);
	frame_sink_model i_frame_sink_model (.mclk, .sys_rst, .slow, .out_ready);

	always #5 mclk = ~mclk;

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	// reference expansion of companded codes into the left-justified linear word
	function automatic logic [15:0] prep_exp(input logic [15:0] d, input logic [1:0] f);
		logic [7:0] a;
		int         t;
		a = d[7:0];
		if (f == 2'h1) begin
			a = a ^ 8'h55;
			t = a[3:0] * 16 + 8;
			if (a[6:4] != 3'h0) t = (t + 256) << (a[6:4] - 1);
			return a[7] ? 16'(t) : 16'(-t);
		end
		if (f == 2'h2) begin
			a = ~a;
			t = (a[3:0] * 8 + 132) << a[6:4];
			return 16'(a[7] ? 132 - t : t - 132) & 16'hfff8;
		end
		return {d[15:3], 3'h0};
	endfunction

	task automatic chk_word(input logic [15:0] got, exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_count(input int got, exp, input string what);
		samples_checked++;
		if (got != exp) begin
			bad_count++;
			$display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
		end
	endtask

	task automatic check_stages();
		int m;
		m = st_q.pop_front();
		chk_count(st_cnt[ST_LP_ANALYSIS], m == 7 ? 2 : 1, "lp analysis runs");
		chk_count(st_cnt[ST_LINE_SPECTRUM_PAIR], 1, "spectral quantizer runs");
		chk_count(st_cnt[ST_OL_PITCH], m < 2 ? 1 : 2, "open loop pitch runs");
		foreach (sub_st[i]) begin
			chk_count(st_cnt[sub_st[i]], 4, "subframe stage runs");
		end
		foreach (st_cnt[i]) st_cnt[i] = 0;
	endtask

	// one frame of 160 samples; mode is presented with the last one and spoiled right after
	task automatic send_frame(input logic [2:0] m);
		logic [15:0] d;
		logic [1:0]  f;
		int          gap;
		for (int i = 0; i < 160; i++) begin
			d = rnd();
			f = 2'(rnd());
			in_valid = 1'b1;
			in_data = d;
			in_fmt = f;
			if (i == 159) mode_sel = m;
			for (int k = 0; k < 5000; k++) begin
				@(posedge mclk);
				if (in_ready) break;
			end
			exp_q.push_back(prep_exp(d, f));
			if (i == 159) mode_q.push_back(m);
			if (i == 159) st_q.push_back(m);
			#1;
			if (i == 159) mode_sel = ~m;
			gap = rnd() % 3;
			if (gap > 0) in_valid = 1'b0;
			repeat (gap) begin
				@(posedge mclk);
				#1;
			end
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge mclk) if (!sys_rst && prep_valid === 1'b1)
		chk_word(prep_sample, exp_q.pop_front(), "prepared sample");

	always @(posedge mclk) begin
		if (!sys_rst && busy === 1'b1 && !busy_d && st_q.size() > 1) check_stages();
		if (!sys_rst && stage_strobe === 1'b1) st_cnt[stage_id]++;
		busy_d <= busy;
	end

	always @(posedge mclk) if (!sys_rst && out_valid === 1'b1 && out_ready) begin
		if (out_frame_start === 1'b1) begin
			if (nbits > 0) chk_count(nbits, bits_tab[omode], "bits in frame");
			omode = mode_q.pop_front();
			chk_word(16'(out_frame_bits), 16'(bits_tab[omode]), "frame bit count");
			chk_word(weight_num_q15, omode > 5 ? 16'h7333 : 16'h7852, "weighting");
			chk_word(16'(pitch_frac_div), omode == 7 ? 16'h0006 : 16'h0003, "pitch res");
			nbits = 0;
		end
		nbits++;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		wrap_up();
	end

	initial begin
		sys_rst = 1'b1;
		in_valid = 1'b0;
		in_data = 16'h0000;
		in_fmt = 2'h0;
		mode_sel = 3'h0;
		slow = 1'b0;
		busy_d = 1'b0;
		repeat (20) @(posedge mclk);
		#1 sys_rst = 1'b0;
		for (int m = 0; m < 8; m++) send_frame(3'(m));
		$display("test all rates done");
		slow = 1'b1;
		send_frame(3'h7);
		send_frame(3'h0);
		in_valid = 1'b0;
		for (int k = 0; k < 5000 && (busy !== 1'b0 || out_valid !== 1'b0); k++) @(posedge mclk);
		repeat (4) @(posedge mclk);
		chk_count(nbits, bits_tab[omode], "bits in last frame");
		chk_count(mode_q.size(), 0, "frames emitted");
		check_stages();
		$display("test stalled sink done");
		wrap_up();
	end
endmodule
`default_nettype wire
